/* File: hw/srm_pkg.sv */
// Constants for the special register map: address layout, register table and flash status.
package srm_pkg;

  // ==========================================================================
  // Bus layout
  localparam int SRM_AW = 11;
  localparam int SRM_NREG = 19;
  localparam logic [10:0] SRM_BIT_WINDOW = 11'h400;
  localparam logic [1:0] SRM_RESP_OKAY = 2'h0;
  localparam logic [1:0] SRM_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register slots in the table below
  localparam int SRM_R_DP_LOW = 0;
  localparam int SRM_R_DP_HIGH = 1;
  localparam int SRM_R_CLK_DIV = 2;
  localparam int SRM_R_AUX_FUNC = 3;
  localparam int SRM_R_CMP_ONE = 4;
  localparam int SRM_R_CMP_TWO = 5;
  localparam int SRM_R_BAUD_CTL = 6;
  localparam int SRM_R_BAUD_LOW = 7;
  localparam int SRM_R_BAUD_HIGH = 8;
  localparam int SRM_R_TW_CTL = 9;
  localparam int SRM_R_TW_DATA = 10;
  localparam int SRM_R_TW_ADDR = 11;
  localparam int SRM_R_TW_CLKH = 12;
  localparam int SRM_R_ARITH = 13;
  localparam int SRM_R_FLASH_CTL = 14;
  localparam int SRM_R_FLASH_DATA = 15;
  localparam int SRM_R_FLASH_ADRL = 16;
  localparam int SRM_R_FLASH_ADRH = 17;
  localparam int SRM_R_OPERAND = 18;

  // ==========================================================================
  // Register index, reset value, writable bits, bits fixed at one
  localparam logic [7:0] SRM_REG_IDX [SRM_NREG] = '{
    8'h82, 8'h83, 8'h95, 8'hA2, 8'hAC, 8'hAD, 8'hBD, 8'hBE, 8'hBF, 8'hD8,
    8'hDA, 8'hDB, 8'hDD, 8'hE0, 8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hF0};
  localparam logic [7:0] SRM_REG_RST [SRM_NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] SRM_REG_WMASK [SRM_NREG] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hF9, 8'h3F, 8'h3F, 8'h03, 8'hFF, 8'hFF, 8'h7D,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] SRM_REG_ONE [SRM_NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // Bit i set: slot i has a listed reset value.
  localparam logic [SRM_NREG-1:0] SRM_REG_HASRST = 19'h7FBFF;
  // Bit i set: slot i accepts single-bit accesses.
  localparam logic [SRM_NREG-1:0] SRM_REG_BITADDR = 19'h42200;

  // ==========================================================================
  // Hardware-set flag positions and flash status layout
  localparam int SRM_CMP_FLAG_BIT = 0;
  localparam int SRM_TW_EVENT_BIT = 3;
  localparam logic [2:0] SRM_FLASH_RSV_VAL = 3'h7;

endpackage

/* File: hw/srm_bit_access.sv */
// Splits a bus byte address into a register index or a single-bit address.
`timescale 1ns/1ps
`default_nettype none

module srm_bit_access
  import srm_pkg::*;
(
  input wire logic [SRM_AW-1:0] addr,
  output logic [7:0] reg_idx,
  output logic is_bit,
  output logic [2:0] bit_pos
);

  // ==========================================================================
  // Decode
  // A bit address shares its upper five bits with its register's index.
  wire logic [7:0] word_w = addr[9:2];
  wire logic bit_win_w = (addr & SRM_BIT_WINDOW) != 11'h000;

  assign is_bit = bit_win_w;
  assign reg_idx = bit_win_w ? {word_w[7:3], 3'h0} : word_w;
  assign bit_pos = bit_win_w ? word_w[2:0] : 3'h0;

endmodule

`default_nettype wire

/* File: hw/srm_axi_port.sv */
// AXI4-Lite slave front end: turns bus transfers into one-cycle register requests.
`timescale 1ns/1ps
`default_nettype none

module srm_axi_port
  import srm_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [SRM_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [SRM_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_req,
  output logic [SRM_AW-1:0] wr_addr,
  output logic [7:0] wr_data,
  output logic wr_lane0,
  input wire logic wr_err,
  output logic rd_req,
  output logic [SRM_AW-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_err
);

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_held_q, w_held_q, ar_held_q;
  logic [SRM_AW-1:0] aw_addr_q, ar_addr_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] rdata_q;

  // ==========================================================================
  // Handshake decode
  wire logic aw_take_w = awvalid & awready_q;
  wire logic w_take_w = wvalid & wready_q;
  wire logic ar_take_w = arvalid & arready_q;
  wire logic b_done_w = bvalid_q & bready;
  wire logic r_done_w = rvalid_q & rready;
  wire logic wr_go_w = aw_held_q & w_held_q & ~bvalid_q;
  wire logic rd_go_w = ar_held_q & ~rvalid_q;

  assign wr_req = wr_go_w;
  assign wr_addr = aw_addr_q;
  assign wr_data = w_data_q;
  assign wr_lane0 = w_lane0_q;
  assign rd_req = rd_go_w;
  assign rd_addr = ar_addr_q;
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = {24'h000000, rdata_q};

  // ==========================================================================
  // Write channel: address and data are taken in either order, then answered.
  always_ff @(posedge mclk) begin
    if (srst) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= SRM_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      if (aw_take_w) begin
        awready_q <= 1'b0;
        aw_held_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (w_take_w) begin
        wready_q <= 1'b0;
        w_held_q <= 1'b1;
        w_data_q <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
      if (wr_go_w) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_err ? SRM_RESP_SLVERR : SRM_RESP_OKAY;
      end
      if (b_done_w) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Read channel
  always_ff @(posedge mclk) begin
    if (srst) begin
      arready_q <= 1'b1;
      ar_held_q <= 1'b0;
      ar_addr_q <= '0;
      rvalid_q <= 1'b0;
      rresp_q <= SRM_RESP_OKAY;
      rdata_q <= 8'h00;
    end else begin
      if (ar_take_w) begin
        arready_q <= 1'b0;
        ar_held_q <= 1'b1;
        ar_addr_q <= araddr;
      end
      if (rd_go_w) begin
        ar_held_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= rd_err ? SRM_RESP_SLVERR : SRM_RESP_OKAY;
        rdata_q <= rd_err ? 8'h00 : rd_data;
      end
      if (r_done_w) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* File: hw/srm_top.sv */
// Special register bank of the controller, reached over AXI4-Lite.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Reserved bits are written as zero; reads may return anything.
// - Bits fixed at zero ignore writes and always read zero.
// - Bits fixed at one are written one and always read one.
// - Bit-addressable registers also take single-bit reads and writes at base plus bit.
// - Flash control reads back busy and error flags, and takes a command on write.
module srm_top
  import srm_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [SRM_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [SRM_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic flash_busy,
  input wire logic high_voltage_abort_flag,
  input wire logic high_voltage_error_flag,
  input wire logic security_violation_flag,
  input wire logic operation_interrupted_flag,
  input wire logic [1:0] cmp_flag_set,
  input wire logic two_wire_event,
  output logic [15:0] data_pointer,
  output logic [7:0] cpu_clock_divider,
  output logic [7:0] auxiliary_function,
  output logic [7:0] comparator_one_control,
  output logic [7:0] comparator_two_control,
  output logic [7:0] baud_generator_control,
  output logic [15:0] baud_divisor,
  output logic [7:0] two_wire_control,
  output logic [7:0] two_wire_data,
  output logic [7:0] two_wire_own_address,
  output logic [7:0] two_wire_clock_high_time,
  output logic [7:0] arith_primary,
  output logic [7:0] second_operand,
  output logic [7:0] flash_data_byte,
  output logic [15:0] flash_address,
  output logic [7:0] flash_command_code,
  output logic flash_command_valid
);

  logic [7:0] reg_q [SRM_NREG];
  logic [7:0] reg_d [SRM_NREG];
  logic [7:0] hw_set_w [SRM_NREG];
  logic [7:0] flash_command_code_q;
  logic flash_command_valid_q;
  logic [SRM_NREG-1:0] wr_hit_w, rd_hit_w;
  logic [7:0] rd_byte_w;
  logic [7:0] rd_one_w;

  logic wr_req_w, wr_lane0_w, rd_req_w;
  logic [SRM_AW-1:0] wr_addr_w, rd_addr_w;
  logic [7:0] wr_data_w;
  logic [7:0] wr_idx_w, rd_idx_w;
  logic wr_is_bit_w, rd_is_bit_w;
  logic [2:0] wr_bit_pos_w, rd_bit_pos_w;
  logic wr_err_w, rd_err_w;
  logic [7:0] rd_data_w;

  // ==========================================================================
  // Bus front end and address split
  srm_axi_port u_port (
    .mclk(mclk),
    .srst(srst),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_req(wr_req_w),
    .wr_addr(wr_addr_w),
    .wr_data(wr_data_w),
    .wr_lane0(wr_lane0_w),
    .wr_err(wr_err_w),
    .rd_req(rd_req_w),
    .rd_addr(rd_addr_w),
    .rd_data(rd_data_w),
    .rd_err(rd_err_w)
  );

  srm_bit_access u_wr_split (
    .addr(wr_addr_w),
    .reg_idx(wr_idx_w),
    .is_bit(wr_is_bit_w),
    .bit_pos(wr_bit_pos_w)
  );

  srm_bit_access u_rd_split (
    .addr(rd_addr_w),
    .reg_idx(rd_idx_w),
    .is_bit(rd_is_bit_w),
    .bit_pos(rd_bit_pos_w)
  );

  // ==========================================================================
  // Decode
  // An access is legal when it hits a defined register, and a bit access only
  // when that register is bit addressable; anything else is answered SLVERR
  // and has no effect.
  wire logic wr_map_w = (|wr_hit_w) & (~wr_is_bit_w | (|(wr_hit_w & SRM_REG_BITADDR)));
  wire logic rd_map_w = (|rd_hit_w) & (~rd_is_bit_w | (|(rd_hit_w & SRM_REG_BITADDR)));
  assign wr_err_w = ~wr_map_w;
  assign rd_err_w = ~rd_map_w;
  wire logic wr_ok_w = wr_req_w & wr_lane0_w & wr_map_w;
  wire logic [7:0] wr_bit_sel_w = 8'h01 << wr_bit_pos_w;
  wire logic [7:0] rd_full_w = rd_byte_w | rd_one_w;
  wire logic rd_bit_val_w = rd_full_w[rd_bit_pos_w];
  assign rd_data_w = rd_is_bit_w ? {7'h00, rd_bit_val_w} : rd_full_w;
  wire logic flash_cmd_wr_w = wr_ok_w & wr_hit_w[SRM_R_FLASH_CTL] & ~wr_is_bit_w;
  wire logic [7:0] flash_status_w = {flash_busy, SRM_FLASH_RSV_VAL, high_voltage_abort_flag,
    high_voltage_error_flag, security_violation_flag, operation_interrupted_flag};

  // ==========================================================================
  // Read data merge
  always_comb begin
    rd_byte_w = 8'h00;
    rd_one_w = 8'h00;
    for (int k = 0; k < SRM_NREG; k++) begin
      if (rd_hit_w[k]) begin
        rd_byte_w = rd_byte_w | reg_q[k];
        rd_one_w = rd_one_w | SRM_REG_ONE[k];
      end
    end
  end

  // ==========================================================================
  // Register storage
  // Outside flash control, only writable bits are ever stored, so fixed-zero
  // and reserved bits keep their reset value of zero. A hardware set in the same
  // cycle as a software clear wins.
  for (genvar i = 0; i < SRM_NREG; i++) begin : g_reg
    wire logic [7:0] sw_byte_w;
    wire logic wr_en_w;

    assign wr_hit_w[i] = wr_idx_w == SRM_REG_IDX[i];
    assign rd_hit_w[i] = rd_idx_w == SRM_REG_IDX[i];
    assign wr_en_w = wr_ok_w & wr_hit_w[i];
    assign sw_byte_w = wr_is_bit_w ?
      ((reg_q[i] & ~wr_bit_sel_w) | ({8{wr_data_w[0]}} & wr_bit_sel_w)) :
      wr_data_w;

    if (i == SRM_R_CMP_ONE) begin : g_set1
      assign hw_set_w[i] = {7'h00, cmp_flag_set[0]} << SRM_CMP_FLAG_BIT;
    end else if (i == SRM_R_CMP_TWO) begin : g_set2
      assign hw_set_w[i] = {7'h00, cmp_flag_set[1]} << SRM_CMP_FLAG_BIT;
    end else if (i == SRM_R_TW_CTL) begin : g_set3
      assign hw_set_w[i] = {7'h00, two_wire_event} << SRM_TW_EVENT_BIT;
    end else begin : g_set0
      assign hw_set_w[i] = 8'h00;
    end

    if (i == SRM_R_FLASH_CTL) begin : g_status
      assign reg_d[i] = flash_status_w;
    end else begin : g_store
      assign reg_d[i] = (wr_en_w ?
        ((sw_byte_w & SRM_REG_WMASK[i]) | (reg_q[i] & ~SRM_REG_WMASK[i])) :
        reg_q[i]) | hw_set_w[i];
    end

    if (SRM_REG_HASRST[i]) begin : g_rst
      always_ff @(posedge mclk) begin
        if (srst) begin
          reg_q[i] <= SRM_REG_RST[i];
        end else begin
          reg_q[i] <= reg_d[i];
        end
      end
    end else begin : g_norst
      // No listed reset value: contents survive reset untouched.
      always_ff @(posedge mclk) begin
        reg_q[i] <= reg_d[i];
      end
    end
  end

  // ==========================================================================
  // Flash command strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      flash_command_code_q <= 8'h00;
      flash_command_valid_q <= 1'b0;
    end else begin
      flash_command_valid_q <= flash_cmd_wr_w;
      if (flash_cmd_wr_w) begin
        flash_command_code_q <= wr_data_w;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign data_pointer = {reg_q[SRM_R_DP_HIGH], reg_q[SRM_R_DP_LOW]};
  assign cpu_clock_divider = reg_q[SRM_R_CLK_DIV];
  assign auxiliary_function = reg_q[SRM_R_AUX_FUNC];
  assign comparator_one_control = reg_q[SRM_R_CMP_ONE];
  assign comparator_two_control = reg_q[SRM_R_CMP_TWO];
  assign baud_generator_control = reg_q[SRM_R_BAUD_CTL];
  assign baud_divisor = {reg_q[SRM_R_BAUD_HIGH], reg_q[SRM_R_BAUD_LOW]};
  assign two_wire_control = reg_q[SRM_R_TW_CTL];
  assign two_wire_data = reg_q[SRM_R_TW_DATA];
  assign two_wire_own_address = reg_q[SRM_R_TW_ADDR];
  assign two_wire_clock_high_time = reg_q[SRM_R_TW_CLKH];
  assign arith_primary = reg_q[SRM_R_ARITH];
  assign second_operand = reg_q[SRM_R_OPERAND];
  assign flash_data_byte = reg_q[SRM_R_FLASH_DATA];
  assign flash_address = {reg_q[SRM_R_FLASH_ADRH], reg_q[SRM_R_FLASH_ADRL]};
  assign flash_command_code = flash_command_code_q;
  assign flash_command_valid = flash_command_valid_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  wire logic rd_byte_go_w = rd_req_w & rd_map_w & ~rd_is_bit_w;
  wire logic wr_byte_go_w = wr_ok_w & ~wr_is_bit_w;

  sequence s_cmd_pulse(logic [7:0] code);
    flash_command_valid && flash_command_code == code ##1 !flash_command_valid;
  endsequence

  a_unmapped_write_err: assert property (
    wr_req_w && !wr_map_w |=> s_axi_bvalid && s_axi_bresp == SRM_RESP_SLVERR)
    else $error("unmapped write not answered with SLVERR");

  a_reserved_not_kept: assert property (
    wr_byte_go_w && wr_hit_w[SRM_R_BAUD_CTL] |=> baud_generator_control[7:2] == 6'h00)
    else $error("reserved bits of baud control were stored");

  a_fixed_zero_read: assert property (
    rd_byte_go_w && rd_hit_w[SRM_R_AUX_FUNC] |=> s_axi_rvalid && s_axi_rdata[2] == 1'b0)
    else $error("fixed-zero bit read back as one");

  a_fixed_one_read: assert property (
    rd_byte_go_w |=> (s_axi_rdata[7:0] & $past(rd_one_w)) == $past(rd_one_w))
    else $error("fixed-one bit read back as zero");

  a_bit_write_lands: assert property (
    wr_ok_w && wr_is_bit_w && wr_hit_w[SRM_R_ARITH]
    |=> arith_primary[$past(wr_bit_pos_w)] == $past(wr_data_w[0]))
    else $error("single-bit write did not reach its bit");

  a_bit_read_value: assert property (
    rd_req_w && rd_map_w && rd_is_bit_w
    |=> s_axi_rdata == {31'h0, $past(rd_full_w[rd_bit_pos_w])})
    else $error("single-bit read returned wrong value");

  a_flash_cmd_pulse: assert property (
    flash_cmd_wr_w |=> s_cmd_pulse($past(wr_data_w)))
    else $error("flash command strobe wrong");

  a_flash_status_read: assert property (
    rd_byte_go_w && rd_hit_w[SRM_R_FLASH_CTL]
    |=> s_axi_rdata[7] == $past(flash_busy, 2) && s_axi_rdata[0] == $past(operation_interrupted_flag, 2))
    else $error("flash status read wrong");

  a_reset_values: assert property (
    disable iff (1'b0) srst |=> arith_primary == 8'h00 && data_pointer == 16'h0000
      && reg_q[SRM_R_FLASH_CTL] == 8'h70 && !flash_command_valid)
    else $error("register not at reset value after reset");

endmodule

`default_nettype wire

/* File: tb/srm_core_model.sv */
// Processor core stand-in that issues register accesses over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module srm_core_model
  import srm_pkg::*;
(
  input wire logic mclk,
  output logic [SRM_AW-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [SRM_AW-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Edges to wait before taking a response; nonzero makes the core slow.
  int unsigned hold_off = 0;

  initial begin
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // ==========
  // Bus transfers
  task automatic bus_write(input logic [SRM_AW-1:0] a, input logic [7:0] d,
                           output logic [1:0] resp);
    int unsigned n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (hold_off == 0);
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~{24'h000000, d};
      end
      if (n >= hold_off && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic bus_read(input logic [SRM_AW-1:0] a, output logic [31:0] d,
                          output logic [1:0] resp);
    int unsigned n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (hold_off == 0);
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (n >= hold_off && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

`default_nettype wire

/* File: tb/srm_top_tb.sv */
// Self-checking bench for the special register bank.
`timescale 1ns/1ps
`default_nettype none

module srm_top_tb import srm_pkg::*;;
  localparam logic [1:0] ok = SRM_RESP_OKAY;
  localparam logic [1:0] er = SRM_RESP_SLVERR;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] flash_flags = 5'h00;
  logic [1:0] cmp_flag_set = 2'h0;
  logic two_wire_event = 1'b0;
  wire [SRM_AW-1:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  wire s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  wire [15:0] data_pointer, flash_address, baud_divisor;
  wire [7:0] arith_primary, flash_command_code;
  wire flash_command_valid;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int cmd_pulses = 0;
  logic [7:0] cmd_last = 8'h00;
  logic [1:0] resp;
  logic [31:0] rdv;

  srm_top i_dut (
    .mclk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .flash_busy(flash_flags[4]), .high_voltage_abort_flag(flash_flags[3]),
    .high_voltage_error_flag(flash_flags[2]), .security_violation_flag(flash_flags[1]),
    .operation_interrupted_flag(flash_flags[0]), .cmp_flag_set, .two_wire_event,
    .data_pointer, .cpu_clock_divider(), .auxiliary_function(), .comparator_one_control(),
    .comparator_two_control(), .baud_generator_control(), .baud_divisor,
    .two_wire_control(), .two_wire_data(), .two_wire_own_address(),
    .two_wire_clock_high_time(), .arith_primary, .second_operand(), .flash_data_byte(),
    .flash_address, .flash_command_code, .flash_command_valid
  );

  srm_core_model i_core (
    .mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  initial forever #2 mclk = ~mclk;

  // ==========
  // Helpers
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (flash_command_valid === 1'b1) begin
      cmd_pulses <= cmd_pulses + 1;
      cmd_last <= flash_command_code;
    end
    if (cycles == 20000) begin
      num_errors++;
      $display("mismatch at %0t: run did not finish", $time);
      complete_run();
    end
  end

  function automatic logic [SRM_AW-1:0] reg_addr(input int i);
    return {1'b0, SRM_REG_IDX[i], 2'b00};
  endfunction

  function automatic logic [SRM_AW-1:0] bit_addr(input logic [7:0] b);
    return SRM_BIT_WINDOW | {1'b0, b, 2'b00};
  endfunction

  // Hardware-set flag bits are written as zero so the pattern never fights them.
  function automatic logic [7:0] wval(input int i, input logic [7:0] pat);
    logic [7:0] hw;
    hw = (i == SRM_R_CMP_ONE || i == SRM_R_CMP_TWO) ? 8'h01 : 8'h00;
    hw = (i == SRM_R_TW_CTL) ? 8'h08 : hw;
    return (pat & SRM_REG_WMASK[i] & ~hw) | SRM_REG_ONE[i];
  endfunction

  task automatic wr(input logic [SRM_AW-1:0] a, input logic [7:0] d, input logic [1:0] e);
    i_core.bus_write(a, d, resp);
    check(resp, e, "write response");
  endtask

  task automatic rd_chk(input logic [SRM_AW-1:0] a, input logic [7:0] d, input logic [1:0] e);
    i_core.bus_read(a, rdv, resp);
    check(resp, e, "read response");
    check(rdv, {24'h000000, d}, "read data");
  endtask

  task automatic check_resets();
    for (int i = 0; i < SRM_NREG; i++) begin
      if (SRM_REG_HASRST[i]) rd_chk(reg_addr(i), SRM_REG_RST[i], ok);
    end
    $display("test reset values done");
  endtask

  // ==========
  // Main sequence
  initial begin
    logic [4:0] f;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    check_resets();
    cmp_flag_set <= 2'h3;
    two_wire_event <= 1'b1;
    @(posedge mclk);
    cmp_flag_set <= 2'h0;
    two_wire_event <= 1'b0;
    rd_chk(reg_addr(SRM_R_CMP_ONE), 8'h01, ok);
    rd_chk(reg_addr(SRM_R_CMP_TWO), 8'h01, ok);
    rd_chk(reg_addr(SRM_R_TW_CTL), 8'h08, ok);
    $display("test hardware flags done");
    for (int p = 0; p < 2; p++) begin
      i_core.hold_off = 3 * p;
      for (int i = 0; i < SRM_NREG; i++) begin
        if (i != SRM_R_FLASH_CTL) wr(reg_addr(i), wval(i, p ? 8'h5A : 8'hA5), ok);
      end
      for (int i = 0; i < SRM_NREG; i++) begin
        if (i != SRM_R_FLASH_CTL) rd_chk(reg_addr(i), wval(i, p ? 8'h5A : 8'hA5), ok);
      end
    end
    i_core.hold_off = 0;
    check(data_pointer, 16'h5A5A, "data pointer");
    check(baud_divisor, 16'h5A5A, "baud divisor");
    check(flash_address, 16'h5A5A, "flash address");
    $display("test register patterns done");
    wr(bit_addr(8'hE3), 8'h00, ok);
    wr(bit_addr(8'hE0), 8'h01, ok);
    wr(bit_addr(8'hF7), 8'h01, ok);
    rd_chk(reg_addr(SRM_R_ARITH), 8'h53, ok);
    rd_chk(reg_addr(SRM_R_OPERAND), 8'hDA, ok);
    rd_chk(bit_addr(8'hE6), 8'h01, ok);
    rd_chk(bit_addr(8'hE7), 8'h00, ok);
    check(arith_primary, 8'h53, "arith output");
    wr(bit_addr(8'hE8), 8'h01, er);
    rd_chk(bit_addr(8'hE8), 8'h00, er);
    wr(11'h204, 8'h00, er);
    rd_chk(11'h204, 8'h00, er);
    $display("test bit and refused access done");
    for (int k = 0; k < 2; k++) begin
      f = k ? 5'h0E : 5'h11;
      flash_flags <= f;
      wr(reg_addr(SRM_R_FLASH_CTL), k ? 8'h3C : 8'hC3, ok);
      @(posedge mclk);
      check(cmd_pulses, k + 1, "command pulses");
      check(cmd_last, k ? 8'h3C : 8'hC3, "command code");
      rd_chk(reg_addr(SRM_R_FLASH_CTL), {f[4], SRM_FLASH_RSV_VAL, f[3:0]}, ok);
    end
    $display("test flash control done");
    srst <= 1'b1;
    flash_flags <= 5'h00;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    check_resets();
    complete_run();
  end
endmodule

`default_nettype wire
